// >>> rtl/eight_bit_reload_timer.sv
// Eight-bit reload timer with Wishbone registers and rollover interrupt
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps

module eight_bit_reload_timer (
    input wire logic clk_i,                // System clock, 250 MHz
    input wire logic rst_n_i,              // Async reset, active low
    input timer_pkg::wb_req_t wb_req_i,    // Wishbone request
    output timer_pkg::wb_rsp_t wb_rsp_o,   // Wishbone answer
    input wire logic ext_count_input_i,    // External count pin
    output logic irq_o                     // Rollover interrupt level
);
    import timer_pkg::*;

    // ----------------------------------------------------------------
    // State and decode signals
    // ----------------------------------------------------------------
    timer_state_t q;          // Registered state
    timer_state_t next_q;     // Next state
    logic req;                // Request present on the bus
    logic acc;                // Edge at which the access completes
    logic wr_en;              // Write on byte lane zero
    logic [IDX_W-1:0] idx;    // Register index
    logic [7:0] wdat;         // Low byte of write data
    logic wr_count;           // Count register write
    logic wr_ie;              // Enable register write
    logic wr_pend;            // Pending register write
    logic wr_reload;          // Reload register write
    logic wr_ctrl;            // Control register write
    logic wr_clr;             // Write-one clear register write
    logic [31:0] rd_val;      // Read value of addressed register

    // ----------------------------------------------------------------
    // Counting path signals
    // ----------------------------------------------------------------
    logic instr_en;           // Instruction clock enable pulse
    logic ext_sync;           // Pin level after synchroniser
    logic ext_rise;           // Rising edge seen at instruction tick
    logic ext_fall;           // Falling edge seen at instruction tick
    logic src_tick;           // Selected source event
    logic run_tick;           // Source event while not halted
    logic presc_clear;        // Clear request to the prescaler
    logic step;               // Prescaled tick: add one to the count
    logic wrap;               // Step taken from the top value
    logic [7:0] presc_cnt;    // Prescaler counter, watched only
    logic halted;             // Stop bit
    logic clr_pend;           // Software clear of the pending flag

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // Writes land at the edge where ack is high, never earlier, so a
    // master that holds its request sees exactly one write per cycle.
    assign req = wb_req_i.cyc & wb_req_i.stb;
    assign acc = req & (q.bus == BUS_ACK);
    assign wr_en = acc & wb_req_i.we & wb_req_i.sel[0];
    assign idx = wb_req_i.adr[7:2];
    assign wdat = wb_req_i.dat[7:0];
    assign wr_count = wr_en & (idx == IDX_COUNT);
    assign wr_ie = wr_en & (idx == IDX_IE);
    assign wr_pend = wr_en & (idx == IDX_PEND);
    assign wr_reload = wr_en & (idx == IDX_RELOAD);
    assign wr_ctrl = wr_en & (idx == IDX_CTRL);
    assign wr_clr = wr_en & (idx == IDX_PEND_CLR);

    // Read mux; unmapped and write-only addresses answer with zero
    always_comb begin
        rd_val = RDATA_NONE;
        case (idx)
            IDX_COUNT: begin
                rd_val[7:0] = q.count;
            end
            IDX_IE: begin
                rd_val[IRQ_BIT] = q.ie;
            end
            IDX_PEND: begin
                rd_val[IRQ_BIT] = q.pend;
            end
            IDX_RELOAD: begin
                rd_val[7:0] = q.reload;
            end
            IDX_CTRL: begin
                rd_val[7:0] = q.ctrl & CTRL_MASK;
            end
            default: begin
                rd_val = RDATA_NONE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Source selection
    // ----------------------------------------------------------------
    // Pin passes two flops before any edge logic looks at it
    level_sync #(
        .WIDTH(1)
    ) u_ext_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .async_i(ext_count_input_i),
        .sync_o(ext_sync)
    );

    // Instruction clock is an enable on every second system cycle
    assign instr_en = q.instr_ph;

    // Edges are judged once per instruction cycle, so a level shorter
    // than one instruction cycle may be missed entirely.
    assign ext_rise = instr_en & ext_sync & !q.ext_prev;
    assign ext_fall = instr_en & !ext_sync & q.ext_prev;

    always_comb begin
        if (q.ctrl[SRC_BIT]) begin
            src_tick = q.ctrl[EDGE_BIT] ? ext_fall : ext_rise;
        end else begin
            src_tick = instr_en;
        end
    end

    // Halting gates the source so prescaler and count both freeze
    assign halted = q.ctrl[HALT_BIT];
    assign run_tick = src_tick & !halted;
    assign presc_clear = wr_ctrl | wr_count;

    // ----------------------------------------------------------------
    // Prescaler
    // ----------------------------------------------------------------
    power2_prescaler #(
        .CNT_W(8)
    ) u_prescaler (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .src_tick_i(run_tick),
        .clear_i(presc_clear),
        .code_i(q.ctrl[PSC_LSB +: PSC_W]),
        .tick_o(step),
        .count_o(presc_cnt)
    );

    assign wrap = step & (q.count == COUNT_MAX);
    assign clr_pend = (wr_pend & !wdat[IRQ_BIT])
        | (wr_clr & wdat[IRQ_BIT]);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_q = q;
        // Bus answer: ack one cycle after the request, for one cycle
        case (q.bus)
            BUS_IDLE: begin
                if (req) begin
                    next_q.bus = BUS_ACK;
                    next_q.rdata = rd_val;
                end
            end
            BUS_ACK: begin
                next_q.bus = BUS_IDLE;
            end
            default: begin
                next_q.bus = BUS_IDLE;
            end
        endcase
        // Instruction clock phase and pin history
        next_q.instr_ph = !q.instr_ph;
        if (instr_en) begin
            next_q.ext_prev = ext_sync;
        end
        // Plain registers
        if (wr_reload) begin
            next_q.reload = wdat;
        end
        if (wr_ctrl) begin
            next_q.ctrl = wdat & CTRL_MASK;
        end
        if (wr_ie) begin
            next_q.ie = wdat[IRQ_BIT];
        end
        // Count: a software write beats a tick in the same cycle
        if (wr_count) begin
            next_q.count = wdat;
        end else if (wrap) begin
            next_q.count = q.reload;
        end else if (step) begin
            next_q.count = q.count + COUNT_ONE;
        end
        // Pending: a rollover in the clear cycle is kept
        if (wrap) begin
            next_q.pend = 1'b1;
        end else if (clr_pend) begin
            next_q.pend = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q.bus <= BUS_IDLE;
            q.rdata <= RDATA_NONE;
            q.count <= COUNT_RST;
            q.reload <= RELOAD_RST;
            q.ctrl <= CTRL_RST;
            q.ie <= 1'b0;
            q.pend <= 1'b0;
            q.instr_ph <= 1'b0;
            q.ext_prev <= 1'b0;
        end else begin
            q <= next_q;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign wb_rsp_o.ack = (q.bus == BUS_ACK);
    assign wb_rsp_o.dat = q.rdata;
    assign irq_o = q.pend & q.ie;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // Ack is a single-cycle answer one cycle after the request
    a_ack_one_cycle: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (req && q.bus == BUS_IDLE) |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack)
        else $error("ack did not pulse once after the request");

    // Count write lands at the ack edge and clears the prescaler
    a_count_write: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_count |=> (q.count == $past(wdat)) && (presc_cnt == 8'h00))
        else $error("count write not taken or prescaler not cleared");

    // Prescale write empties the prescaler counter
    a_psc_clear: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_ctrl |=> presc_cnt == 8'h00)
        else $error("prescaler not cleared by control write");

    // A tick below the top adds exactly one
    a_inc_by_one: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (step && !wrap && !wr_count)
        |=> q.count == $past(q.count) + COUNT_ONE)
        else $error("count did not advance by one");

    // Rollover reloads and flags the event
    a_reload_wrap: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (wrap && !wr_count)
        |=> (q.count == $past(q.reload)) && q.pend)
        else $error("rollover did not reload or set pending");

    // Halted timer keeps its count and sets no flag
    a_halt_hold: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (halted && !wr_count && !wr_ctrl) [*2]
        |-> (q.count == $past(q.count)) && !wrap)
        else $error("count moved while halted");

    // Interrupt needs both enable and pending
    a_irq_gating: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(irq_o) |-> $past(wrap) || $past(wr_ie && wdat[IRQ_BIT]))
        else $error("interrupt rose without a cause");

    // Instruction clock source never steps twice in a row
    a_instr_rate: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (step && !q.ctrl[SRC_BIT]) |=> !step)
        else $error("instruction source stepped faster than Fsys/2");

    // Code 0 in instruction mode steps on every instruction cycle
    a_div_one: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (instr_en && !halted && !q.ctrl[SRC_BIT] && !presc_clear
         && q.ctrl[PSC_LSB +: PSC_W] == 4'h0) |-> step)
        else $error("divide-by-one did not step");

    // Software clear without a rollover empties the flag
    a_pend_clear: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (clr_pend && !wrap) |=> !q.pend)
        else $error("pending flag not cleared by software");

    // External edges come only on instruction ticks
    a_ext_edge: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (ext_rise || ext_fall) |-> instr_en)
        else $error("pin edge taken off the instruction tick");

    // Halt freezes the prescaler; the control write that resumes also clears it
    a_halt_presc: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (halted && !presc_clear) |=> presc_cnt == $past(presc_cnt))
        else $error("prescaler moved while halted");

    // Pending holds until software clears it
    a_pend_sticky: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (q.pend && !clr_pend) |=> q.pend)
        else $error("pending flag dropped without a clear");

    // Every rollover flags, even when a clear collides; a count write cancels the step
    a_wrap_flags: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        wrap |=> q.pend)
        else $error("rollover did not set pending");

    // Enable bit takes the written value at the ack edge
    a_ie_write: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_ie |=> q.ie == $past(wdat[IRQ_BIT]))
        else $error("interrupt enable not taken");

    // Registers are a byte wide; the upper read lanes stay zero
    a_rdata_upper: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        wb_rsp_o.ack |-> wb_rsp_o.dat[31:8] == 24'h00_0000)
        else $error("read data above the low byte not zero");

    // In pin mode the count moves only on the selected pin edge
    a_pin_step: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (step && q.ctrl[SRC_BIT])
        |-> (q.ctrl[EDGE_BIT] ? ext_fall : ext_rise))
        else $error("pin mode stepped without the selected edge");

endmodule

// >>> rtl/timer_pkg.sv
// Shared constants, bus carriers and state types of the reload timer
package timer_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam int unsigned IDX_W = 6;
    localparam logic [5:0] IDX_COUNT = 6'h01;    // Timer count
    localparam logic [5:0] IDX_IE = 6'h0b;       // Interrupt enable
    localparam logic [5:0] IDX_PEND = 6'h0c;     // Interrupt pending
    localparam logic [5:0] IDX_RELOAD = 6'h10;   // Reload value
    localparam logic [5:0] IDX_CTRL = 6'h11;     // Timer control
    localparam logic [5:0] IDX_PEND_CLR = 6'h12; // Write-one clear

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int unsigned IRQ_BIT = 4;  // Rollover bit in ie/pending
    localparam int unsigned HALT_BIT = 6; // Control: stop counting
    localparam int unsigned EDGE_BIT = 5; // Control: falling edge
    localparam int unsigned SRC_BIT = 4;  // Control: external source
    localparam int unsigned PSC_LSB = 0;  // Control: prescale code
    localparam int unsigned PSC_W = 4;    // Prescale code width

    // ----------------------------------------------------------------
    // Values after reset and fixed values
    // ----------------------------------------------------------------
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] RELOAD_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CTRL_MASK = 8'h7f; // Bit 7 reads zero
    localparam logic [7:0] COUNT_MAX = 8'hff; // Last value before reload
    localparam logic [7:0] COUNT_ONE = 8'h01;
    localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Timing: instruction clock is the system clock over two
    // ----------------------------------------------------------------
    localparam int unsigned INSTR_DIV = 2;
    localparam int unsigned SYNC_STAGES = 2;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic cyc;         // Bus cycle
        logic stb;         // Strobe
        logic we;          // Write enable
        logic [7:0] adr;   // Byte address
        logic [3:0] sel;   // Byte lane selects
        logic [31:0] dat;  // Write data
    } wb_req_t;

    typedef struct packed {
        logic ack;         // Acknowledge
        logic [31:0] dat;  // Read data
    } wb_rsp_t;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } bus_state_t;

    typedef struct packed {
        bus_state_t bus;      // Slave answer phase
        logic [31:0] rdata;   // Registered read data
        logic [7:0] count;    // Timer count
        logic [7:0] reload;   // Reload value
        logic [7:0] ctrl;     // Timer control
        logic ie;             // Rollover interrupt enable
        logic pend;           // Rollover pending
        logic instr_ph;       // Instruction clock phase
        logic ext_prev;       // Pin level at last instruction tick
    } timer_state_t;

endpackage

// >>> rtl/level_sync.sv
// Two-flop synchroniser for levels arriving from outside the clock
`timescale 1ns/1ps
module level_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk_i,               // System clock
    input wire logic rst_n_i,             // Async reset, active low
    input wire logic [WIDTH-1:0] async_i, // Unsynchronised level
    output logic [WIDTH-1:0] sync_o       // Level after two flops
);
    import timer_pkg::*;

    // ----------------------------------------------------------------
    // Stages
    // ----------------------------------------------------------------
    logic [SYNC_STAGES-1:0][WIDTH-1:0] stage; // Only stage 1 is read

    // Elaboration check; the shift below assumes exactly two stages
    if (WIDTH < 1 || SYNC_STAGES != 2) begin : g_bad_width
        $error("level_sync: WIDTH below one or stages not two");
    end

    // First flop feeds only the second one
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stage <= '0;
        end else begin
            stage <= {stage[0], async_i};
        end
    end

    assign sync_o = stage[1];

endmodule

// >>> rtl/power2_prescaler.sv
// Power-of-two prescaler with a saturating top code
`timescale 1ns/1ps
module power2_prescaler #(
    parameter int unsigned CNT_W = 8
) (
    input wire logic clk_i,            // System clock
    input wire logic rst_n_i,          // Async reset, active low
    input wire logic src_tick_i,       // One pulse per source event
    input wire logic clear_i,          // Zero the internal counter
    input wire logic [3:0] code_i,     // Divide by two to this power, 256 at most
    output logic tick_o,               // Prescaled tick, one cycle
    output logic [CNT_W-1:0] count_o   // Internal counter, for checks
);
    import timer_pkg::*;

    // ----------------------------------------------------------------
    // Counter and match mask
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] cnt;       // Source events since last clear
    logic [CNT_W-1:0] mask;      // Low bits that must all be one
    logic [CNT_W-1:0] next_cnt;

    // Elaboration check; the top code relies on an eight-bit span
    if (CNT_W != 8) begin : g_bad_width
        $error("power2_prescaler: only an 8-bit counter is served");
    end

    // Codes with the top bit set all divide by the full counter span
    always_comb begin
        if (code_i[3]) begin
            mask = '1;
        end else begin
            mask = CNT_W'((1 << code_i[2:0]) - 1);
        end
        tick_o = src_tick_i & !clear_i & ((cnt & mask) == mask);
        if (clear_i) begin
            next_cnt = '0;
        end else if (src_tick_i) begin
            next_cnt = cnt + CNT_W'(1);
        end else begin
            next_cnt = cnt;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign count_o = cnt;

endmodule

// >>> testbench/ext_pulse_source.sv
// Behavioural pulse source that drives the external count pin
`timescale 1ns/1ps
module ext_pulse_source #(
    parameter int unsigned HALF_CLKS = 4 // Clocks per level, above two
) (
    input wire logic clk_i,           // System clock
    input wire logic rst_n_i,         // Async reset, active low
    input wire logic start_i,         // Load a burst of level changes
    input wire logic [7:0] toggles_i, // Level changes in the burst
    output logic pin_o,               // Level on the count pin
    output logic busy_o               // Burst still running
);
    // ----------------------------------------------------------------
    // Burst state
    // ----------------------------------------------------------------
    logic [7:0] left; // Level changes still to make
    logic [7:0] hold; // Clocks spent on the present level

    assign busy_o = (left != 8'h00);

    // Toggle the pin every HALF_CLKS clocks; between bursts the pin keeps
    // its last level, as a real driver that stays enabled would
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_o <= 1'b0;
            left <= 8'h00;
            hold <= 8'h00;
        end else if (start_i) begin
            left <= toggles_i;
            hold <= 8'h00;
        end else if (left != 8'h00) begin
            // Each level lasts more than one instruction cycle
            if (hold == 8'(HALF_CLKS - 1)) begin
                pin_o <= ~pin_o;
                left <= left - 8'h01;
                hold <= 8'h00;
            end else begin
                hold <= hold + 8'h01;
            end
        end
    end
endmodule

// >>> testbench/eight_bit_reload_timer_tb.sv
// Self-checking bench for the eight-bit reload timer
`timescale 1ns/1ps
module eight_bit_reload_timer_tb;
    import timer_pkg::*;
    // ----------------------------------------------------------------
    // Bench signals
    // ----------------------------------------------------------------
    localparam int LIMIT = 60000; // Whole run needs about 15000 cycles
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    wb_req_t wb_req = '0;
    wb_rsp_t wb_rsp;
    logic pin;
    logic irq;
    logic src_start = 1'b0;
    logic [7:0] src_toggles = 8'h00;
    logic src_busy;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int t0, t1, t2, div;
    logic [5:0] regs [7] = '{IDX_COUNT, IDX_IE, IDX_PEND, IDX_RELOAD,
        IDX_CTRL, IDX_PEND_CLR, 6'h20};
    logic [3:0] codes [4] = '{4'h0, 4'h3, 4'h7, 4'hf};

    // Clock at 250 MHz
    always #2 clk_i = ~clk_i;

    // Cycle count; a hang ends the run as a mismatch
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            err_count = err_count + 1;
            stop_test();
        end
    end

    eight_bit_reload_timer dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
        .ext_count_input_i(pin), .irq_o(irq));

    ext_pulse_source src (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .start_i(src_start), .toggles_i(src_toggles), .pin_o(pin),
        .busy_o(src_busy));

    // ----------------------------------------------------------------
    // Bus and compare tasks
    // ----------------------------------------------------------------
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic fail(input logic [31:0] got, input logic [31:0] exp);
        err_count++;
        $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) fail(32'(got), 32'(exp));
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) fail(32'(got), 32'(exp));
    endtask

    task automatic chk_cycles(input int got, input int exp);
        samples_checked++;
        if (got != exp) fail(got, exp);
    endtask

    // One classic cycle: hold until ack is sampled, then one idle cycle
    task automatic bus(input logic we, input logic [5:0] idx,
                       input logic [7:0] wdat, output logic [7:0] rdat);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00},
                    sel: 4'hf, dat: {24'h00_0000, wdat}};
        @(posedge clk_i);
        // Only the bench timeout ends a wait for the answer
        while (wb_rsp.ack !== 1'b1) begin
            @(posedge clk_i);
        end
        rdat = wb_rsp.dat[7:0];
        wb_req <= '0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [7:0] unused;
        bus(1'b1, idx, d, unused);
    endtask

    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        bus(1'b0, idx, 8'h00, d);
        chk_byte(d, exp);
    endtask

    // Wait, bounded, for the interrupt level; returns the cycle seen
    task automatic wait_irq(output int t);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 20000) begin
            n++;
            @(posedge clk_i);
        end
        if (n == 20000) err_count++;
        t = cycles;
    endtask

    // Burst of pin changes, then let the synchroniser settle
    task automatic pulses(input logic [7:0] n, input logic [7:0] exp);
        int k;
        k = 0;
        src_toggles <= n;
        src_start <= 1'b1;
        @(posedge clk_i);
        src_start <= 1'b0;
        @(posedge clk_i);
        while (src_busy === 1'b1 && k < 200) begin
            k++;
            @(posedge clk_i);
        end
        repeat (8) @(posedge clk_i);
        rd_chk(IDX_COUNT, exp);
    endtask

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        // Reset values, write-only clear and an unmapped place read zero
        foreach (regs[i]) rd_chk(regs[i], 8'h00);
        wr(IDX_CTRL, 8'hff);
        rd_chk(IDX_CTRL, 8'h7f);
        // Halted: count holds at the rollover value and no flag appears
        wr(IDX_CTRL, 8'h40);
        wr(IDX_COUNT, 8'hff);
        repeat (600) @(posedge clk_i);
        rd_chk(IDX_COUNT, 8'hff);
        rd_chk(IDX_PEND, 8'h00);
        wr(IDX_RELOAD, 8'hf0);
        wr(IDX_IE, 8'hff);
        rd_chk(IDX_IE, 8'h10);
        // First period after a control write, then the steady period
        foreach (codes[i]) begin
            div = codes[i][3] ? 256 : (1 << codes[i]);
            wr(IDX_CTRL, {4'h4, codes[i]});
            wr(IDX_COUNT, 8'hff);
            wr(IDX_PEND, 8'h00);
            wr(IDX_CTRL, {4'h0, codes[i]});
            t0 = cycles;
            wait_irq(t1);
            chk_bit(t1 - t0 >= 2 * div - 4 && t1 - t0 <= 2 * div + 4,
                    1'b1);
            if (codes[i] != 4'h0) rd_chk(IDX_COUNT, 8'hf0);
            rd_chk(IDX_PEND, 8'h10);
            wr(IDX_PEND, 8'h10);
            rd_chk(IDX_PEND, 8'h10);
            wr(IDX_PEND_CLR, 8'h10);
            wait_irq(t2);
            chk_cycles(t2 - t1, 2 * div * 16);
        end
        // Masking: the flag stays, the request follows the enable
        wr(IDX_IE, 8'h00);
        chk_bit(irq, 1'b0);
        rd_chk(IDX_PEND, 8'h10);
        wr(IDX_IE, 8'h10);
        chk_bit(irq, 1'b1);
        wr(IDX_PEND, 8'h00);
        chk_bit(irq, 1'b0);
        // Count write while running restarts a full prescaler period
        wr(IDX_COUNT, 8'hff);
        rd_chk(IDX_COUNT, 8'hff);
        t0 = cycles;
        wait_irq(t1);
        chk_bit(t1 - t0 >= 500 && t1 - t0 <= 515, 1'b1);
        // Pin mode: three changes from low give two rising edges
        wr(IDX_CTRL, 8'h50);
        wr(IDX_COUNT, 8'h00);
        wr(IDX_CTRL, 8'h10);
        pulses(8'h03, 8'h02);
        // Falling edges: three changes from high give two falls
        wr(IDX_CTRL, 8'h70);
        wr(IDX_COUNT, 8'h00);
        wr(IDX_CTRL, 8'h30);
        pulses(8'h03, 8'h02);
        stop_test();
    end
endmodule
